/* File: rtl/dds_deser.sv */
// ddr 1-to-16 deserializer with divider, phase select and lane order
//
// Contract
// - the serial stream is split into sixteen lanes at 1/16 the bit rate.
// - three divide-by-two stages in series derive the internal clocks.
// - the word-rate clock, bit rate over sixteen, is forwarded with the lanes.
// - while preset is active all divider stages are held at zero.
// - preset is resampled on the falling half-rate clock edge before use.
// - one serial bit is taken on every rising and every falling edge while preset is inactive.
// - lanes update as whole sixteen-bit words, one per forwarded clock period.
// - forwarded clock phase moves only in quarter-period steps by two selects.
// - selects high,low: 00 gives 270, 01 gives 180, 10 gives 90, 11 gives 0.
// - lane order low puts the first bit on lane 15, high on lane 0.
`timescale 1ns/1ps
`default_nettype none
module dds_deser #(
    parameter int LANES = dds_pkg::WORD_W,
    parameter int DEPTH = dds_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // serial side
    input wire logic half_rate_clock_in_i,
    input wire logic serial_data_in_i,
    input wire logic divider_preset_i,
    output logic serial_ready_o,
    // controls
    input wire logic phase_select_high_i,
    input wire logic phase_select_low_i,
    input wire logic lane_order_i,
    // parallel lanes and forwarded clock
    output logic [dds_pkg::WORD_W-1:0] lane_data_o,
    output logic word_strobe_o,
    output logic word_rate_clock_o,
    output logic overflow_o,
    // buffered word stream
    output logic word_valid_o,
    input wire logic word_ready_i,
    output logic [dds_pkg::WORD_W-1:0] word_data_o
);
    import dds_pkg::*;

    // ------------------------------------------------------------
    // half-rate clock edge detection
    // ------------------------------------------------------------
    logic c2_prev_r;
    logic c2_prev_nxt;
    logic c2_rise;
    logic c2_fall;

    always_comb begin
        c2_prev_nxt = half_rate_clock_in_i;
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            c2_prev_r <= 1'b0;
        end else begin
            c2_prev_r <= c2_prev_nxt;
        end
    end

    // the sampling clock comes only from outside
    // a pin already high at reset release reads as a rise
    always_comb begin
        c2_rise = half_rate_clock_in_i && !c2_prev_r;
        c2_fall = !half_rate_clock_in_i && c2_prev_r;
    end

    // ------------------------------------------------------------
    // preset retiming
    // ------------------------------------------------------------
    logic preset_r;
    logic preset_nxt;

    always_comb begin
        preset_nxt = preset_r;
        // the pin counts only at a falling edge, between edges it is ignored
        if (c2_fall) begin
            preset_nxt = divider_preset_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            preset_r <= PRESET_RST;
        end else begin
            preset_r <= preset_nxt;
        end
    end

    // ------------------------------------------------------------
    // divider chain
    // ------------------------------------------------------------
    logic [DIV_STAGES-1:0] div_q;
    logic [DIV_STAGES:0] div_carry;

    assign div_carry[0] = 1'b1;

    // each stage toggles when all lower stages are high
    // stage 0 runs at a quarter, stage 1 at an eighth, stage 2 at the
    // word rate of the serial bits; a clear outranks a toggle, so a rise
    // during preset still leaves the chain at zero
    for (genvar g = 0; g < DIV_STAGES; g++) begin : g_div
        dds_div2 u_div2 (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .tick_i(c2_rise),
            .carry_i(div_carry[g]),
            .clear_i(preset_r),
            .q_o(div_q[g]),
            .carry_o(div_carry[g+1])
        );
    end

    // ------------------------------------------------------------
    // forwarded clock phase selection
    // ------------------------------------------------------------
    logic [2:0] phase_ofs;
    logic [2:0] phase_cnt;
    logic fwd_clk_r;
    logic fwd_clk_nxt;

    always_comb begin
        case ({phase_select_high_i, phase_select_low_i})
            2'b00: phase_ofs = PH_OFS_270;
            2'b01: phase_ofs = PH_OFS_180;
            2'b10: phase_ofs = PH_OFS_90;
            2'b11: phase_ofs = PH_OFS_0;
            default: phase_ofs = PH_OFS_270;
        endcase
    end

    // offsets of two half-rate periods are quarter word periods
    assign phase_cnt = div_q + phase_ofs;

    // ------------------------------------------------------------
    // forwarded clock register
    // ------------------------------------------------------------
    // registered so the pin cannot glitch while the sum ripples

    always_comb begin
        fwd_clk_nxt = phase_cnt[DIV_STAGES-1];
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            fwd_clk_r <= 1'b0;
        end else begin
            fwd_clk_r <= fwd_clk_nxt;
        end
    end

    assign word_rate_clock_o = fwd_clk_r;

    // ------------------------------------------------------------
    // demultiplexer slot decode
    // ------------------------------------------------------------
    logic [SLOT_W-1:0] slot;
    logic [SLOT_W-1:0] lane_idx;
    logic take_bit;
    logic word_done;
    logic fifo_ready;

    // slot follows divider count, so the boundary tracks preset
    always_comb begin
        if (c2_rise) begin
            slot = {div_q, 1'b0};
        end else begin
            slot = {div_q - 3'h1, 1'b1};
        end
    end

    // no bit is taken while the retimed preset holds the divider
    always_comb begin
        take_bit = 1'b0;
        word_done = 1'b0;
        if (!preset_r) begin
            take_bit = c2_rise || c2_fall;
            word_done = c2_fall && (slot == LAST_SLOT);
        end
    end

    // ------------------------------------------------------------
    // lane select
    // ------------------------------------------------------------
    always_comb begin
        if (lane_order_i) begin
            lane_idx = slot;
        end else begin
            lane_idx = LAST_SLOT - slot;
        end
    end

    // ------------------------------------------------------------
    // word assembly
    // ------------------------------------------------------------
    logic [LANES-1:0] asm_r;
    logic [LANES-1:0] asm_nxt;

    // bits of a cut word stay in their lanes until overwritten
    always_comb begin
        asm_nxt = asm_r;
        if (take_bit) begin
            asm_nxt[lane_idx] = serial_data_in_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            asm_r <= WORD_RST;
        end else begin
            asm_r <= asm_nxt;
        end
    end

    // ------------------------------------------------------------
    // parallel word register
    // ------------------------------------------------------------
    logic [LANES-1:0] lane_r;
    logic [LANES-1:0] lane_nxt;
    logic strobe_r;
    logic strobe_nxt;

    // the last bit joins its word in the same cycle
    always_comb begin
        lane_nxt = lane_r;
        strobe_nxt = 1'b0;
        if (word_done) begin
            lane_nxt = asm_nxt;
            strobe_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            lane_r <= WORD_RST;
            strobe_r <= 1'b0;
        end else begin
            lane_r <= lane_nxt;
            strobe_r <= strobe_nxt;
        end
    end

    // ------------------------------------------------------------
    // overflow flag
    // ------------------------------------------------------------
    logic ovf_r;
    logic ovf_nxt;

    // sticky until reset: set when the buffer refuses a finished word,
    // so it marks a word that really was lost
    always_comb begin
        ovf_nxt = ovf_r;
        if (strobe_r && !fifo_ready) begin
            ovf_nxt = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= ovf_nxt;
        end
    end

    // ------------------------------------------------------------
    // lane and flag outputs
    // ------------------------------------------------------------
    assign lane_data_o = lane_r;
    assign word_strobe_o = strobe_r;
    assign overflow_o = ovf_r;

    // ------------------------------------------------------------
    // word buffer
    // ------------------------------------------------------------
    // the word enters one cycle after its last bit, with the strobe
    dds_fifo #(
        .WIDTH(LANES),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .in_valid_i(strobe_r),
        .in_ready_o(fifo_ready),
        .in_data_i(lane_r),
        .out_valid_o(word_valid_o),
        .out_ready_i(word_ready_i),
        .out_data_o(word_data_o)
    );

    // ------------------------------------------------------------
    // back-pressure
    // ------------------------------------------------------------
    // advisory only: the source cannot be stalled inside a word, so it
    // may not start a word that has no room
    assign serial_ready_o = fifo_ready;
endmodule
`default_nettype wire

/* File: rtl/dds_pkg.sv */
// constants shared by the ddr deserializer design files
package dds_pkg;
    // word, divider and buffer geometry
    localparam int WORD_W = 16;
    localparam int SLOT_W = 4;
    localparam int DIV_STAGES = 3;
    localparam int FIFO_DEPTH = 16;

    // forwarded clock phase offsets, in half-rate clock periods
    localparam logic [2:0] PH_OFS_0 = 3'h0;
    localparam logic [2:0] PH_OFS_90 = 3'h2;
    localparam logic [2:0] PH_OFS_180 = 3'h4;
    localparam logic [2:0] PH_OFS_270 = 3'h6;

    // reset values and last slot index
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
    localparam logic [DIV_STAGES-1:0] DIV_RST = 3'h0;
    localparam logic PRESET_RST = 1'b0;
    localparam logic [SLOT_W-1:0] LAST_SLOT = 4'hf;
endpackage

/* File: rtl/dds_div2.sv */
// one divide-by-two stage of the divider chain
`timescale 1ns/1ps
`default_nettype none
module dds_div2 (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // chain control
    input wire logic tick_i,
    input wire logic carry_i,
    input wire logic clear_i,
    // stage output
    output logic q_o,
    output logic carry_o
);
    logic q_r;
    logic q_nxt;

    always_comb begin
        q_nxt = q_r;
        if (clear_i) begin
            q_nxt = 1'b0;
        end else if (tick_i && carry_i) begin
            q_nxt = ~q_r;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            q_r <= 1'b0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;
    assign carry_o = carry_i & q_r;
endmodule
`default_nettype wire

/* File: rtl/dds_fifo.sv */
// word fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dds_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] wr_nxt;
    logic [AW-1:0] rd_r;
    logic [AW-1:0] rd_nxt;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o = mem_r[rd_r];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        wr_nxt = wr_r;
        rd_nxt = rd_r;
        cnt_nxt = cnt_r;
        if (push) begin
            wr_nxt = (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
        end
        if (pop) begin
            rd_nxt = (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
        end
        if (push && !pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_r[wr_r] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

/* File: verification/dds_deser_assertions.sv */
// port assertions for the ddr deserializer
`timescale 1ns/1ps
`default_nettype none
module dds_deser_assertions
    import dds_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic half_rate_clock_in_i,
    input wire logic divider_preset_i,
    input wire logic phase_select_high_i,
    input wire logic phase_select_low_i,
    input wire logic serial_ready_o,
    input wire logic [dds_pkg::WORD_W-1:0] lane_data_o,
    input wire logic word_strobe_o,
    input wire logic word_rate_clock_o,
    input wire logic overflow_o,
    input wire logic word_valid_o,
    input wire logic word_ready_i,
    input wire logic [dds_pkg::WORD_W-1:0] word_data_o
);
    logic prev_r, pre_r, up_r, fall, last;
    logic [2:0] div_r, sum;
    assign fall = prev_r & ~half_rate_clock_in_i;
    assign last = fall & ~pre_r & (div_r == 3'h0);
    assign sum = div_r + {~phase_select_high_i, ~phase_select_low_i, 1'b0};
    // divider mirror: counts rises, held clear while retimed preset is up
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            prev_r <= 1'b0;
            pre_r <= 1'b0;
            up_r <= 1'b0;
            div_r <= 3'h0;
        end else begin
            prev_r <= half_rate_clock_in_i;
            up_r <= 1'b1;
            if (fall)
                pre_r <= divider_preset_i;
            if (pre_r)
                div_r <= 3'h0;
            else if (half_rate_clock_in_i & ~prev_r)
                div_r <= div_r + 3'h1;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    fwd_phase_a:
        assert property (up_r |-> word_rate_clock_o == $past(sum[2]))
        else $error("forwarded clock phase wrong");
    strobe_time_a:
        assert property (up_r |-> word_strobe_o == $past(last))
        else $error("word strobe misplaced");
    strobe_once_a:
        assert property (word_strobe_o |=> !word_strobe_o)
        else $error("word strobe too long");
    lanes_hold_a:
        assert property (up_r && !word_strobe_o |-> $stable(lane_data_o))
        else $error("lanes moved without strobe");
    preset_quiet_a:
        assert property (pre_r ##1 pre_r |-> !word_strobe_o)
        else $error("word during preset");
    word_push_a:
        assert property (word_strobe_o |=> word_valid_o)
        else $error("word not queued");
    ovf_set_a:
        assert property (word_strobe_o && !serial_ready_o && !word_ready_i
            |-> ##[1:2] overflow_o)
        else $error("overflow not flagged");
    head_hold_a:
        assert property (word_valid_o && !word_ready_i
            |=> word_valid_o && $stable(word_data_o))
        else $error("queue head lost");
endmodule
`default_nettype wire

/* File: verification/dds_src.sv */
// serial source: half-rate clock and one bit per edge
`timescale 1ns/1ps
`default_nettype none
module dds_src (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [15:0] word_i,
    input wire logic [4:0] nb_i,
    output logic hrc_o,
    output logic sdat_o,
    output logic busy_o
);
    logic [5:0] left_r;
    logic [15:0] sh_r;
    assign busy_o = left_r != 6'h0;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            left_r <= 6'h0;
            sh_r <= 16'h0000;
            hrc_o <= 1'b0;
            sdat_o <= 1'b0;
        end else if (go_i) begin
            left_r <= {nb_i, 1'b0};
            sh_r <= word_i;
        end else if (busy_o) begin
            left_r <= left_r - 6'h1;
            if (!left_r[0]) begin
                hrc_o <= ~hrc_o;
                sdat_o <= sh_r[0];
                sh_r <= sh_r >> 1;
            end
        end else
            sdat_o <= ~sdat_o; // clock stands still, data wanders
    end
endmodule
`default_nettype wire

/* File: verification/dds_deser_tb.sv */
// self-checking bench for the ddr deserializer
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
    err_total++; $display("Error %s expected %h seen %h", n, e, s); end end
module dds_deser_tb;
    import dds_pkg::*;
    logic mclk_i = 1'b0, rst_i = 1'b1, divider_preset_i = 1'b0;
    logic phase_select_high_i = 1'b0, phase_select_low_i = 1'b0;
    logic lane_order_i = 1'b0, word_ready_i = 1'b0, go = 1'b0, mix = 1'b0;
    logic half_rate_clock_in_i, serial_data_in_i, serial_ready_o, busy;
    logic word_strobe_o, word_rate_clock_o, overflow_o, word_valid_o;
    logic [WORD_W-1:0] lane_data_o, word_data_o, w = 16'h0000, e, h;
    logic [WORD_W-1:0] q1[$], q2[$];
    logic [4:0] nb = 5'h00;
    logic [31:0] rs = 32'h5a, rw = 32'h5a;
    int err_total = 0, total_checks = 0, cyc = 0;

    dds_src i_dds_src (.mclk_i, .rst_i, .go_i(go), .word_i(w), .nb_i(nb),
        .hrc_o(half_rate_clock_in_i), .sdat_o(serial_data_in_i),
        .busy_o(busy));
    dds_deser i_dds_deser (.*);

    always #5 mclk_i = ~mclk_i;

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    function automatic logic [15:0] rev(input logic [15:0] v);
        for (int j = 0; j < 16; j++)
            rev[j] = v[15 - j];
    endfunction

    task automatic end_of_test();
        if (err_total == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // full words queue their expected lane image
    task automatic send(input logic [15:0] v, input logic [4:0] n);
        w <= v;
        nb <= n;
        go <= 1'b1;
        @(posedge mclk_i);
        go <= 1'b0;
        if (n == 5'h10)
            q1.push_back(lane_order_i ? v : rev(v));
        for (int t = 0; t < 40 && (t < 2 || busy); t++)
            @(posedge mclk_i);
        repeat (3) @(posedge mclk_i);
    endtask

    always @(posedge mclk_i) begin
        cyc++;
        if (cyc > 5000) begin
            err_total++;
            end_of_test();
        end
    end

    // a new word meets the buffer before the head leaves it
    always @(posedge mclk_i) begin
        if (mix) begin
            rs = xs(rs);
            word_ready_i <= rs[0];
        end
        if (!rst_i && word_strobe_o) begin
            e = (q1.size() > 0) ? q1.pop_front() : ~lane_data_o;
            `CHK("lanes", e, lane_data_o)
            if (q2.size() < FIFO_DEPTH)
                q2.push_back(e);
        end
        if (!rst_i && word_valid_o && word_ready_i) begin
            h = (q2.size() > 0) ? q2.pop_front() : ~word_data_o;
            `CHK("fifo", h, word_data_o)
        end
    end

    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        // every lane order and phase select
        for (int i = 0; i < 8; i++) begin
            {lane_order_i, phase_select_high_i, phase_select_low_i} <= 3'(i);
            send(i[0] ? 16'hffff >> i : 16'h0001 << i, 5'h10);
        end
        // misalign with a partial word, then realign through the preset
        send(16'h0000, 5'h06);
        divider_preset_i <= 1'b1;
        send(16'hffff, 5'h02);
        divider_preset_i <= 1'b0;
        send(16'hffff, 5'h02);
        send(16'h1234, 5'h10);
        for (int i = 0; i < 9; i++) begin
            rw = xs(rw);
            send(rw[15:0], 5'h10);
        end
        `CHK("ready", 1'b0, serial_ready_o)
        `CHK("overflow", 1'b1, overflow_o)
        word_ready_i <= 1'b1;
        for (int t = 0; t < 40 && word_valid_o !== 1'b0; t++)
            @(posedge mclk_i);
        mix <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            rw = xs(rw);
            {lane_order_i, phase_select_high_i, phase_select_low_i} <= rw[18:16];
            send(rw[15:0], 5'h10);
        end
        mix <= 1'b0;
        @(posedge mclk_i);
        word_ready_i <= 1'b1;
        repeat (20) @(posedge mclk_i);
        `CHK("drain", 1'b0, word_valid_o)
        `CHK("missing", 32'h0, 32'(q1.size()))
        end_of_test();
    end
endmodule
bind dds_deser dds_deser_assertions i_dds_deser_assertions (.*);
`default_nettype wire
